/* rtl/cache_maint_sequencer.sv */
// Execute-stage sequencer for cache invalidate and cache push instructions.
// Assumes start_i pulses once as such an instruction enters execute.
`default_nettype none
module cache_maint_sequencer
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire pipe_timing_pkg::maint_op_t op_i,
	input wire logic drained_i,
	input wire logic line_dirty_i,
	input wire logic line_xfer_done_i,
	output logic busy_o,
	output logic done_o,
	output logic push_req_o,
	output logic [pipe_timing_pkg::SLOT_W-1:0] push_slot_o,
	output logic [pipe_timing_pkg::MCNT_W-1:0] idle_clks_o
);
	typedef enum logic [1:0] {st_idle, st_fixed, st_slot} seq_state_t;
	seq_state_t state;
	pipe_timing_pkg::maint_op_t op;
	logic [pipe_timing_pkg::MCNT_W-1:0] cnt;
	logic drain_seen;
	logic go;
	logic is_line;
	logic fixed_last;
	logic slot_dirty;
	logic slot_done;

	// The fixed part waits until earlier writes and prefetches are gone.
	assign go = drained_i || drain_seen;
	assign is_line = (op == pipe_timing_pkg::push_line_op);
	assign fixed_last = (state == st_fixed) && go && (cnt == 9'h001);
	assign slot_dirty = is_line || line_dirty_i;
	assign slot_done = !slot_dirty || line_xfer_done_i;
	assign busy_o = (state != st_idle);
	assign push_req_o = (state == st_slot) && slot_dirty;
	// A clean line push ends in its last fixed clock; page and all walk every slot.
	assign done_o = (fixed_last && !(op == pipe_timing_pkg::push_page_op)
		&& !(op == pipe_timing_pkg::push_all_op) && !(is_line && line_dirty_i))
		|| ((state == st_slot) && slot_done
		&& (is_line || push_slot_o == pipe_timing_pkg::PUSH_LAST_SLOT));

	// Sequence state.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state <= st_idle;
		else
		begin
			case (state)
			st_idle:
				if (start_i)
					state <= st_fixed;
			st_fixed:
				if (fixed_last)
					state <= done_o ? st_idle : st_slot;
			st_slot:
				if (done_o)
					state <= st_idle;
			default:
				state <= st_idle;
			endcase
		end
	end

	// Fixed-clock countdown and idle counter; idle clocks do not consume the count.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			op <= pipe_timing_pkg::op_none;
			cnt <= 9'h000;
			drain_seen <= 1'b0;
			idle_clks_o <= 9'h000;
		end
		else if ((state == st_idle) && start_i)
		begin
			op <= op_i;
			cnt <= pipe_timing_pkg::fixed_clks(op_i);
			drain_seen <= 1'b0;
			idle_clks_o <= 9'h000;
		end
		else if ((state == st_fixed) && go)
		begin
			cnt <= cnt - 9'h001;
			drain_seen <= 1'b1;
		end
		else if ((state == st_fixed) && (idle_clks_o != 9'h1FF))
			idle_clks_o <= idle_clks_o + 9'h001;
	end

	// Line slot index for page and whole-cache pushes.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			push_slot_o <= 8'h00;
		else if (state != st_slot)
			push_slot_o <= 8'h00;
		else if (slot_done && !done_o)
			push_slot_o <= push_slot_o + 8'h01;
	end

	// Clocks since the operation entered execute, and whether any line was pushed.
	logic [15:0] age;
	logic saw_dirty;
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			age <= 16'h0000;
			saw_dirty <= 1'b0;
		end
		else if (!busy_o)
		begin
			age <= 16'h0000;
			saw_dirty <= 1'b0;
		end
		else
		begin
			age <= age + 16'h0001;
			saw_dirty <= saw_dirty || push_req_o;
		end
	end

	default clocking chk_cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_invalidate_length: assert property (
		(done_o && (op == pipe_timing_pkg::invalidate_page_op))
		|-> age + 16'h0001 == 16'(pipe_timing_pkg::INV_PAGE_CLKS) + 16'(idle_clks_o))
		else $error("page invalidate length wrong");
	chk_invalidate_short: assert property (
		(done_o && ((op == pipe_timing_pkg::invalidate_line_op)
		|| (op == pipe_timing_pkg::invalidate_all_op)))
		|-> age + 16'h0001 == 16'(pipe_timing_pkg::INV_LINE_CLKS) + 16'(idle_clks_o))
		else $error("line or all invalidate length wrong");
	chk_clean_push_length: assert property (
		(done_o && !saw_dirty && !push_req_o && (op == pipe_timing_pkg::push_page_op))
		|-> age + 16'h0001 == 16'(pipe_timing_pkg::PUSH_HEAD_CLKS)
		+ 16'(pipe_timing_pkg::PUSH_SLOTS) + 16'(idle_clks_o))
		else $error("clean page push length wrong");
	chk_idle_holds_count: assert property (
		((state == st_fixed) && !go) |=> $stable(cnt) && (state == st_fixed))
		else $error("maintenance ran before pipe drained");
	cov_page_invalidate: cover property (done_o && (op == pipe_timing_pkg::invalidate_page_op));
	cov_dirty_push: cover property (push_req_o && line_xfer_done_i);
endmodule
`default_nettype wire

/* rtl/integer_pipeline_stall_timing.sv */
// Four-stage integer pipeline occupancy: calculate, fetch, execute, write-back.
// Assumes a decoder presenting one instruction's timing per issue, and a data
// memory unit, cache and bus controller answering the request outputs.
//
// Behaviour
// - Simple instructions spend one clock in each of calculate, fetch and execute; with no write they never enter write-back.
// - False-condition trap is single-clock per stage and never drains the pipe.
// - Write-back performs its memory write only while data memory is idle.
// - An operand read from the fetch stage beats a pending write-back.
// - Lead time absorbs waiting; effective address load has three lead clocks.
// - An instruction waits in fetch while execute is busy, then runs base time.
// - Extension-word formats hold calculate for waits beyond the lead time.
// - Interrupt priority inputs are sampled every clock during cache maintenance.
// - Maintenance waits for earlier writes and prefetches; those clocks are idle.
// - Invalidate timing ignores which caches are selected.
// - Calculate is frozen while a maintenance instruction is ahead of it.
// - Line and all invalidates take 9 plus idle; page invalidate 266 plus idle.
// - Clean push takes 6 for a line, 267 for page or whole cache.
// - Dirty push adds one transfer to a line; page or all is 11 plus 256 transfers.
// - Push length follows dirty lines, transfer length and bus wait states.
// - Execute time is a lead time plus a base time.
`default_nettype none
module integer_pipeline_stall_timing
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic issue_valid_i,
	output logic issue_ready_o,
	input wire logic [pipe_timing_pkg::CALC_W-1:0] calc_clks_i,
	input wire logic [pipe_timing_pkg::LEAD_W-1:0] lead_clks_i,
	input wire logic [pipe_timing_pkg::BASE_W-1:0] base_clks_i,
	input wire logic ext_format_i,
	input wire logic effective_address_load_i,
	input wire logic operand_fetch_i,
	input wire logic mem_write_i,
	input wire pipe_timing_pkg::maint_op_t maint_op_i,
	input wire logic [pipe_timing_pkg::CSEL_W-1:0] cache_sel_i,
	input wire logic [pipe_timing_pkg::IPL_W-1:0] interrupt_priority_inputs_i,
	input wire logic dmu_busy_i,
	input wire logic prefetch_empty_i,
	input wire logic wbuf_empty_i,
	input wire logic line_dirty_i,
	input wire logic line_xfer_done_i,
	output logic calc_busy_o,
	output logic fetch_busy_o,
	output logic exec_busy_o,
	output logic wb_busy_o,
	output logic operand_read_o,
	output logic mem_write_o,
	output logic retire_o,
	output logic ipl_sample_o,
	output logic [pipe_timing_pkg::IPL_W-1:0] ipl_sampled_o,
	output logic maint_busy_o,
	output logic [pipe_timing_pkg::CSEL_W-1:0] maint_cache_sel_o,
	output logic push_req_o,
	output logic [pipe_timing_pkg::SLOT_W-1:0] push_slot_o,
	output logic [pipe_timing_pkg::MCNT_W-1:0] idle_clks_o
);
	// Calculate stage.
	logic ca_v;
	logic [pipe_timing_pkg::CALC_W-1:0] ca_cnt;
	logic [pipe_timing_pkg::LEAD_W-1:0] ca_lead;
	logic [pipe_timing_pkg::BASE_W-1:0] ca_base;
	logic ca_ext;
	logic ca_rd;
	logic ca_wr;
	pipe_timing_pkg::maint_op_t ca_op;
	logic [pipe_timing_pkg::CSEL_W-1:0] ca_csel;
	// Fetch stage.
	logic fe_v;
	logic [pipe_timing_pkg::WAIT_W-1:0] fe_wait;
	logic [pipe_timing_pkg::LEAD_W-1:0] fe_lead;
	logic [pipe_timing_pkg::BASE_W-1:0] fe_base;
	logic fe_rd;
	logic fe_wr;
	pipe_timing_pkg::maint_op_t fe_op;
	logic [pipe_timing_pkg::CSEL_W-1:0] fe_csel;
	// Execute stage.
	logic ex_v;
	logic [pipe_timing_pkg::EX_W-1:0] ex_cnt;
	logic ex_wr;
	pipe_timing_pkg::maint_op_t ex_op;
	// Stage movement.
	logic ca_done;
	logic ca_leave;
	logic fe_leave;
	logic fe_free;
	logic ex_maint;
	logic ex_last;
	logic ex_leave;
	logic ex_free;
	logic ext_hold;
	logic maint_ahead;
	logic wb_accept;
	logic seq_done;
	logic seq_start;
	logic drained;

	// Execute ends on its countdown, or on the sequencer for maintenance;
	// ordinary instructions, the false-condition trap included, never wait to drain.
	assign ex_maint = pipe_timing_pkg::is_maint(ex_op);
	assign ex_last = ex_v && (ex_maint ? seq_done : (ex_cnt == 5'h01));
	assign ex_leave = ex_last && (!ex_wr || wb_accept);
	assign ex_free = !ex_v || ex_leave;
	assign fe_leave = fe_v && ex_free;
	assign fe_free = !fe_v || fe_leave;

	// Extension-word formats may not run ahead further than their lead time covers.
	assign ext_hold = ca_ext && ex_v && !ex_maint
		&& (ex_cnt > (pipe_timing_pkg::EX_W'(ca_lead) + 5'h02));
	// Nothing behind a maintenance instruction may reach the caches.
	assign maint_ahead = (fe_v && pipe_timing_pkg::is_maint(fe_op)) || (ex_v && ex_maint);
	assign ca_done = ca_v && (ca_cnt == 4'h1);
	assign ca_leave = ca_done && fe_free && !ext_hold && !maint_ahead;
	assign issue_ready_o = !ca_v || ca_leave;

	// Requests and status seen outside.
	assign operand_read_o = fe_v && fe_rd && (fe_wait == 3'h0);
	assign retire_o = ex_leave;
	assign ipl_sample_o = maint_busy_o || ex_leave;
	assign calc_busy_o = ca_v;
	assign fetch_busy_o = fe_v;
	assign exec_busy_o = ex_v;
	assign seq_start = fe_leave && pipe_timing_pkg::is_maint(fe_op);
	assign drained = !wb_busy_o && prefetch_empty_i && wbuf_empty_i;

	// Calculate stage: takes an issue, counts its clocks, then holds until it may move.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ca_v <= 1'b0;
			ca_cnt <= 4'h0;
			ca_lead <= 2'h0;
			ca_base <= 4'h0;
			ca_ext <= 1'b0;
			ca_rd <= 1'b0;
			ca_wr <= 1'b0;
			ca_op <= pipe_timing_pkg::op_none;
			ca_csel <= 2'h0;
		end
		else if (issue_valid_i && issue_ready_o)
		begin
			ca_v <= 1'b1;
			ca_cnt <= pipe_timing_pkg::at_least_one(calc_clks_i);
			ca_lead <= effective_address_load_i ? pipe_timing_pkg::EA_LOAD_LEAD_CLKS
				: lead_clks_i;
			ca_base <= pipe_timing_pkg::at_least_one(base_clks_i);
			ca_ext <= ext_format_i;
			ca_rd <= operand_fetch_i;
			ca_wr <= mem_write_i;
			ca_op <= maint_op_i;
			ca_csel <= cache_sel_i;
		end
		else if (ca_leave)
			ca_v <= 1'b0;
		else if (ca_v && (ca_cnt != 4'h1))
			ca_cnt <= ca_cnt - 4'h1;
	end

	// Fetch stage: one clock for the operand, then counts clocks spent waiting.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fe_v <= 1'b0;
			fe_wait <= 3'h0;
			fe_lead <= 2'h0;
			fe_base <= 4'h0;
			fe_rd <= 1'b0;
			fe_wr <= 1'b0;
			fe_op <= pipe_timing_pkg::op_none;
			fe_csel <= 2'h0;
		end
		else if (ca_leave)
		begin
			fe_v <= 1'b1;
			fe_wait <= 3'h0;
			fe_lead <= ca_lead;
			fe_base <= ca_base;
			fe_rd <= ca_rd;
			fe_wr <= ca_wr;
			fe_op <= ca_op;
			fe_csel <= ca_csel;
		end
		else if (fe_leave)
			fe_v <= 1'b0;
		else if (fe_v && (fe_wait != pipe_timing_pkg::WAIT_MAX))
			fe_wait <= fe_wait + 3'h1;
	end

	// Execute stage: the lead time is spent first by any wait in fetch.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ex_v <= 1'b0;
			ex_cnt <= 5'h00;
			ex_wr <= 1'b0;
			ex_op <= pipe_timing_pkg::op_none;
			maint_cache_sel_o <= 2'h0;
		end
		else if (fe_leave)
		begin
			ex_v <= 1'b1;
			ex_cnt <= pipe_timing_pkg::exec_len(fe_base, fe_lead, fe_wait);
			ex_wr <= fe_wr;
			ex_op <= fe_op;
			maint_cache_sel_o <= fe_csel;
		end
		else if (ex_leave)
			ex_v <= 1'b0;
		else if (ex_v && (ex_cnt != 5'h01))
			ex_cnt <= ex_cnt - 5'h01;
	end

	// Interrupt priority capture: every clock in maintenance, else per boundary.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ipl_sampled_o <= 3'h0;
		else if (ipl_sample_o)
			ipl_sampled_o <= interrupt_priority_inputs_i;
	end

	// A single write-back entry; its arbitration keeps operand reads first.
	writeback_arbiter u_wb
	(
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.load_i(ex_leave && ex_wr),
		.dmu_busy_i(dmu_busy_i),
		.read_req_i(operand_read_o),
		.accept_o(wb_accept),
		.pending_o(wb_busy_o),
		.write_o(mem_write_o)
	);

	// Cache maintenance timing; it never sees the cache selection.
	cache_maint_sequencer u_maint
	(
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.start_i(seq_start),
		.op_i(fe_op),
		.drained_i(drained),
		.line_dirty_i(line_dirty_i),
		.line_xfer_done_i(line_xfer_done_i),
		.busy_o(maint_busy_o),
		.done_o(seq_done),
		.push_req_o(push_req_o),
		.push_slot_o(push_slot_o),
		.idle_clks_o(idle_clks_o)
	);

	// Expected fetch-wait plus execute clocks, kept apart from the countdown.
	logic [pipe_timing_pkg::EX_W-1:0] chk_age;
	logic [pipe_timing_pkg::EX_W-1:0] chk_total;
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			chk_age <= 5'h00;
			chk_total <= 5'h00;
		end
		else if (fe_leave)
		begin
			chk_age <= pipe_timing_pkg::EX_W'(fe_wait);
			chk_total <= pipe_timing_pkg::EX_W'(fe_base) + ((fe_wait > 3'(fe_lead))
				? pipe_timing_pkg::EX_W'(fe_wait) : pipe_timing_pkg::EX_W'(fe_lead));
		end
		else if (ex_v && (chk_age != 5'h1F))
			chk_age <= chk_age + 5'h01;
	end

	default clocking chk_cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_simple_one_clock: assert property (
		(issue_valid_i && issue_ready_o && !ca_v && !fe_v && !ex_v && !mem_write_i
		&& (calc_clks_i == 4'h1) && (base_clks_i == 4'h1) && (lead_clks_i == 2'h0)
		&& !effective_address_load_i && (maint_op_i == pipe_timing_pkg::op_none))
		|=> calc_busy_o ##1 fetch_busy_o ##1 (exec_busy_o && retire_o))
		else $error("simple instruction did not pass in one clock per stage");
	chk_plain_no_drain: assert property (
		(ex_v && !ex_maint && (ex_cnt == 5'h01) && !ex_wr) |-> retire_o)
		else $error("ordinary instruction waited for the pipe to drain");
	chk_lead_absorbed: assert property (
		(ex_leave && !ex_maint && !ex_wr && (chk_age != 5'h1F))
		|-> (chk_age + 5'h01 == chk_total))
		else $error("execute time does not match lead plus base");
	chk_fetch_waits: assert property (
		(fe_v && ex_v && !ex_leave && (fe_wait != pipe_timing_pkg::WAIT_MAX))
		|=> fe_v && (fe_wait == $past(fe_wait) + 3'h1))
		else $error("instruction left fetch while execute was busy");
	chk_ext_interlock: assert property (
		(ca_done && ca_ext && ex_v && !ex_maint && (ex_cnt > 5'h05))
		|-> !issue_ready_o ##1 calc_busy_o)
		else $error("extension-word instruction left calculate too early");
	chk_ipl_each_clock: assert property (
		maint_busy_o |-> ipl_sample_o ##1 (ipl_sampled_o == $past(interrupt_priority_inputs_i)))
		else $error("priority inputs not sampled during maintenance");
	chk_calc_frozen: assert property (
		(ca_v && maint_ahead) |-> !issue_ready_o)
		else $error("calculate advanced behind a maintenance instruction");
	chk_wb_request_gated: assert property (
		operand_read_o |-> !mem_write_o)
		else $error("write-back won against an operand read");
	cov_ext_hold: cover property (ca_done && ext_hold && fe_free);
	cov_ea_load_absorbed: cover property (fe_leave && (fe_lead == 2'h3) && (fe_wait == 3'h3));
endmodule
`default_nettype wire

/* rtl/writeback_arbiter.sv */
// Write-back stage holding one pending memory write and its data memory arbitration.
// Assumes read_req_i is the fetch stage's operand read for the current clock.
`default_nettype none
module writeback_arbiter
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic load_i,
	input wire logic dmu_busy_i,
	input wire logic read_req_i,
	output logic accept_o,
	output logic pending_o,
	output logic write_o
);
	// The write goes out only when the memory is idle and no operand read competes.
	assign write_o = pending_o && !dmu_busy_i && !read_req_i;
	assign accept_o = !pending_o || write_o;

	// One entry is enough: execute stalls on a second write rather than losing it.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pending_o <= 1'b0;
		else if (load_i)
			pending_o <= 1'b1;
		else if (write_o)
			pending_o <= 1'b0;
	end

	default clocking chk_cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_wb_memory_idle: assert property (
		write_o |-> pending_o && !dmu_busy_i)
		else $error("write-back issued while data memory busy");
	chk_wb_loses_read: assert property (
		(pending_o && read_req_i) |-> !write_o ##1 pending_o)
		else $error("write-back did not yield to operand read");
	cov_wb_stalled_by_read: cover property (pending_o && read_req_i && !dmu_busy_i);
endmodule
`default_nettype wire

/* shared/pipe_timing_pkg.sv */
// Constants, types and helpers shared by the integer pipeline timing model.
// Assumes one processor bus clock; the timing figures below are counts of that clock.
`default_nettype none
package pipe_timing_pkg;
	// Field widths of the per-instruction timing descriptor and helpers.
	localparam int unsigned CALC_W = 4;
	localparam int unsigned LEAD_W = 2;
	localparam int unsigned BASE_W = 4;
	localparam int unsigned WAIT_W = 3;
	localparam int unsigned EX_W = 5;
	localparam int unsigned MCNT_W = 9;
	localparam int unsigned SLOT_W = 8;
	localparam int unsigned IPL_W = 3;
	localparam int unsigned CSEL_W = 2;
	// Lead time of the effective address load instruction.
	localparam logic [LEAD_W-1:0] EA_LOAD_LEAD_CLKS = 2'h3;
	// Saturation value of the fetch-stage wait counter.
	localparam logic [WAIT_W-1:0] WAIT_MAX = 3'h7;
	// Fixed execute clocks of the cache maintenance operations, idle excluded.
	localparam logic [MCNT_W-1:0] INV_LINE_CLKS = 9'h009;
	localparam logic [MCNT_W-1:0] INV_PAGE_CLKS = 9'h10A;
	localparam logic [MCNT_W-1:0] INV_ALL_CLKS = 9'h009;
	localparam logic [MCNT_W-1:0] PUSH_LINE_CLKS = 9'h006;
	localparam logic [MCNT_W-1:0] PUSH_HEAD_CLKS = 9'h00B;
	localparam logic [MCNT_W-1:0] PUSH_SLOTS = 9'h100;
	localparam logic [SLOT_W-1:0] PUSH_LAST_SLOT = SLOT_W'(PUSH_SLOTS - 9'h001);

	// Cache maintenance operation carried by an instruction.
	typedef enum logic [2:0] {
		op_none,
		invalidate_line_op,
		invalidate_page_op,
		invalidate_all_op,
		push_line_op,
		push_page_op,
		push_all_op
	} maint_op_t;

	// True for any cache invalidate or cache push instruction.
	function automatic logic is_maint(input maint_op_t op);
		return op != op_none;
	endfunction

	// Fixed part of a maintenance operation; cache selection plays no part.
	function automatic logic [MCNT_W-1:0] fixed_clks(input maint_op_t op);
		case (op)
		invalidate_line_op: return INV_LINE_CLKS;
		invalidate_page_op: return INV_PAGE_CLKS;
		invalidate_all_op: return INV_ALL_CLKS;
		push_line_op: return PUSH_LINE_CLKS;
		push_page_op: return PUSH_HEAD_CLKS;
		push_all_op: return PUSH_HEAD_CLKS;
		default: return 9'h001;
		endcase
	endfunction

	// Stage counts of zero are treated as one clock.
	function automatic logic [BASE_W-1:0] at_least_one(input logic [BASE_W-1:0] n);
		return (n == 4'h0) ? 4'h1 : n;
	endfunction

	// Execute clocks: base time plus whatever lead time the wait did not absorb.
	function automatic logic [EX_W-1:0] exec_len(input logic [BASE_W-1:0] base,
		input logic [LEAD_W-1:0] lead, input logic [WAIT_W-1:0] waited);
		logic [EX_W-1:0] left;
		left = (EX_W'(waited) >= EX_W'(lead)) ? 5'h00 : (EX_W'(lead) - EX_W'(waited));
		return EX_W'(base) + left;
	endfunction
endpackage
`default_nettype wire

/* tb/integer_pipeline_stall_timing_test.sv */
// Self-checking bench for the pipeline timing block.
// Assumes the partner model answers prefetch and line transfer requests.
`default_nettype none
module integer_pipeline_stall_timing_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic vld = 1'b0, eal = 1'b0, opf = 1'b0, wr = 1'b0, busy_dmu = 1'b0, dirty = 1'b0;
	logic ext = 1'b0;
	logic [3:0] base = 4'h1, pf = 4'h0, line = 4'h1;
	logic [1:0] lead = 2'h0, sel = 2'h0;
	logic [2:0] ipl = 3'h0;
	pipe_timing_pkg::maint_op_t op = pipe_timing_pkg::op_none;
	logic rdy, cb, fb, eb, wbb, rd, mw, ret, ips, mb, preq, pfe, xd;
	logic [2:0] ipls;
	logic [8:0] idle;
	logic [1:0] csel;
	logic [7:0] slot;
	int fail_count = 0;
	int checks_done = 0;
	int n;
	// Clock at 250 MHz.
	always #2 clk = ~clk;
	integer_pipeline_stall_timing u_dut (.core_clk_i(clk), .rst_n_i(rst_n),
		.issue_valid_i(vld), .issue_ready_o(rdy), .calc_clks_i(4'h1), .lead_clks_i(lead),
		.base_clks_i(base), .ext_format_i(ext), .effective_address_load_i(eal),
		.operand_fetch_i(opf), .mem_write_i(wr), .maint_op_i(op), .cache_sel_i(sel),
		.interrupt_priority_inputs_i(ipl), .dmu_busy_i(busy_dmu), .prefetch_empty_i(pfe),
		.wbuf_empty_i(1'b1), .line_dirty_i(dirty), .line_xfer_done_i(xd), .calc_busy_o(cb),
		.fetch_busy_o(fb), .exec_busy_o(eb), .wb_busy_o(wbb), .operand_read_o(rd),
		.mem_write_o(mw), .retire_o(ret), .ipl_sample_o(ips), .ipl_sampled_o(ipls),
		.maint_busy_o(mb), .maint_cache_sel_o(csel), .push_req_o(preq), .push_slot_o(slot),
		.idle_clks_o(idle));
	mem_side_model u_mem (.core_clk_i(clk), .rst_n_i(rst_n), .maint_busy_i(mb),
		.push_req_i(preq), .pf_clks_i(pf), .line_clks_i(line), .prefetch_empty_o(pfe),
		.line_xfer_done_o(xd));
	task automatic results();
		if (fail_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Offers one descriptor; calculate is free, so the second edge takes it.
	task automatic issue(input logic [3:0] b, input logic l, input logic o, input logic w,
		input pipe_timing_pkg::maint_op_t m);
		@(posedge clk);
		vld <= 1'b1;
		base <= b;
		eal <= l;
		opf <= o;
		wr <= w;
		op <= m;
		@(posedge clk);
		vld <= 1'b0;
	endtask
	task automatic to_retire();
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (ret !== 1'b1 && n < 900);
	endtask
	task automatic t_simple();
		issue(4'h1, 1'b0, 1'b0, 1'b0, pipe_timing_pkg::op_none);
		to_retire();
		chk(10'(n), 10'h003);
		chk(10'({cb, fb, eb}), 10'h001);
	endtask
	// Long execute ahead; the lead time soaks up the whole wait in fetch.
	task automatic t_lead();
		issue(4'h5, 1'b0, 1'b0, 1'b0, pipe_timing_pkg::op_none);
		issue(4'h1, 1'b1, 1'b0, 1'b0, pipe_timing_pkg::op_none);
		to_retire();
		chk(10'(n), 10'h005);
		to_retire();
		chk(10'(n), 10'h001);
	endtask
	// An extension-word instruction behind a long execute stays in calculate for the
	// clocks its lead time cannot cover, so it still waits exactly its lead in fetch.
	task automatic t_ext();
		issue(4'h6, 1'b0, 1'b0, 1'b0, pipe_timing_pkg::op_none);
		ext <= 1'b1;
		lead <= 2'h1;
		issue(4'h4, 1'b0, 1'b0, 1'b0, pipe_timing_pkg::op_none);
		ext <= 1'b0;
		lead <= 2'h0;
		repeat (5) @(negedge clk);
		chk(10'({cb, fb}), 10'h001);
		to_retire();
		chk(10'(n), 10'h001);
		to_retire();
		chk(10'(n), 10'h004);
	endtask
	// A busy data memory, then an operand read, both hold the write back.
	task automatic t_wb();
		@(posedge clk);
		busy_dmu <= 1'b1;
		issue(4'h1, 1'b0, 1'b0, 1'b1, pipe_timing_pkg::op_none);
		to_retire();
		@(negedge clk);
		chk(10'({wbb, mw}), 10'h002);
		@(posedge clk);
		busy_dmu <= 1'b0;
		@(negedge clk);
		chk(10'({wbb, mw}), 10'h003);
		issue(4'h1, 1'b0, 1'b0, 1'b1, pipe_timing_pkg::op_none);
		issue(4'h1, 1'b0, 1'b1, 1'b0, pipe_timing_pkg::op_none);
		to_retire();
		@(negedge clk);
		chk(10'({rd, mw}), 10'h002);
		@(negedge clk);
		chk(10'({rd, mw}), 10'h001);
	endtask
	task automatic t_maint(input pipe_timing_pkg::maint_op_t m, input logic [3:0] idl,
		input logic d, input logic [9:0] exp);
		int bz;
		int miss;
		logic [9:0] last;
		bz = 0;
		miss = 0;
		// Page and whole-cache pushes end on the last slot; the others never walk slots.
		last = (m == pipe_timing_pkg::push_page_op || m == pipe_timing_pkg::push_all_op)
			? 10'h0FF : 10'h000;
		@(posedge clk);
		pf <= idl;
		dirty <= d;
		ipl <= ipl + 3'h3;
		sel <= sel + 2'h1;
		issue(4'h1, 1'b0, 1'b0, 1'b0, m);
		repeat (900)
		begin
			@(negedge clk);
			if (mb === 1'b1)
				bz++;
			if (mb === 1'b1 && ips !== 1'b1)
				miss++;
			if (ret === 1'b1)
				break;
		end
		chk(10'(bz), exp);
		chk(10'(miss), 10'h000);
		chk({1'b0, idle}, 10'(idl));
		chk(10'(ipls), 10'(ipl));
		chk(10'(csel), 10'(sel));
		chk(10'(slot), last);
	endtask
	// Watchdog well beyond the roughly twelve hundred clocks of the run.
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results();
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_simple();
		t_lead();
		t_ext();
		t_wb();
		t_maint(pipe_timing_pkg::invalidate_line_op, 4'h0, 1'b0, 10'd9);
		t_maint(pipe_timing_pkg::invalidate_page_op, 4'h0, 1'b0, 10'd266);
		t_maint(pipe_timing_pkg::invalidate_all_op, 4'h4, 1'b0, 10'd13);
		t_maint(pipe_timing_pkg::push_line_op, 4'h0, 1'b0, 10'd6);
		t_maint(pipe_timing_pkg::push_page_op, 4'h0, 1'b0, 10'd267);
		@(posedge clk);
		line <= 4'h3;
		t_maint(pipe_timing_pkg::push_line_op, 4'h2, 1'b1, 10'd11);
		@(posedge clk);
		line <= 4'h2;
		t_maint(pipe_timing_pkg::push_all_op, 4'h0, 1'b1, 10'd523);
		results();
	end
endmodule
`default_nettype wire

/* tb/mem_side_model.sv */
// Behavioural prefetch queue and bus controller facing the pipeline.
// Assumes the bench sets idle and line lengths before each maintenance op.
`default_nettype none
module mem_side_model
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic maint_busy_i,
	input wire logic push_req_i,
	input wire logic [3:0] pf_clks_i,
	input wire logic [3:0] line_clks_i,
	output logic prefetch_empty_o,
	output logic line_xfer_done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pf_cnt;
	logic [3:0] xfer_cnt;
	// Prefetches drain one a clock only once maintenance stalls the core.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			pf_cnt <= 4'h0;
		else if (!maint_busy_i)
			pf_cnt <= pf_clks_i;
		else if (pf_cnt != 4'h0)
			pf_cnt <= pf_cnt - 4'h1;
	// A transfer lasts line_clks_i clocks, so wait states stretch it.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			xfer_cnt <= 4'h0;
		else if (line_xfer_done_o || !push_req_i)
			xfer_cnt <= 4'h0;
		else
			xfer_cnt <= xfer_cnt + 4'h1;
	// Done pulses in the last transfer clock only, never while idle.
	assign prefetch_empty_o = (pf_cnt == 4'h0);
	assign line_xfer_done_o = push_req_i && (xfer_cnt == line_clks_i - 4'h1);
endmodule
`default_nettype wire
